/* hdl/ccc_regs.sv */
// APB register bank with channel configuration and calibration words.
// Assumes an APB master on pclk; the converter datapath reads the
// decoded field outputs, all driven straight from flip-flops.
//
// Register access over APB was chosen for this implementation.
`timescale 1ns/1ps

// Summary of operation
// - Config bits 15:6 hold a signed phase delay, reset zero.
// - Config bit 2 set disables DC filtering for that channel only.
// - Config bits 1:0 pick pins, shorted, positive or negative test.
// - Upper offset register gives offset bits 23:8, two's complement.
// - Lower offset bits 15:8 give offset bits 7:0; low byte zero.
// - Gain is unsigned 24-bit, upper register gives bits 23:8.
// - Lower gain bits 15:8 give gain bits 7:0; low byte zero.
// - Upper gain resets to 8000h, lower to 0000h, gain one.
// - Channel 0 offset registers reset to zero, at indices 0Ah and 0Bh.
// - Channel 1 config at 0Eh, upper offset at 0Fh, same layout.
// - Channel 0 lower gain register at index 0Dh, reset zero.
// - Shared register holds the 4-bit global DC filter setting.
module ccc_regs
   import ccc_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic [9:0] chan0_phase_delay,
   output logic chan0_dc_filter_off,
   output ccc_pkg::ccc_sel_t chan0_input_select,
   output logic [23:0] chan0_offset,
   output logic [23:0] chan0_gain,
   output logic [9:0] chan1_phase_delay,
   output logic chan1_dc_filter_off,
   output ccc_pkg::ccc_sel_t chan1_input_select,
   output logic [15:0] chan1_offset_upper,
   output logic [3:0] global_dc_filter_setting
);
   import ccc_pkg::*;

   localparam int NREG = 8;

   logic setup;
   logic [7:0] word_idx;
   logic aligned;
   logic hit;
   logic [NREG-1:0] sel_vec;
   logic [NREG-1:0] wr_vec;
   logic [15:0] wr_word;
   logic [15:0] rd_vals [NREG];
   logic [15:0] rd_mux;
   logic [31:0] prdata_reg;
   logic [31:0] prdata_next;
   logic pready_reg;
   logic pready_next;
   logic pslverr_reg;
   logic pslverr_next;
   logic [15:0] chan0_config;
   logic [15:0] ch0_ofs_hi;
   logic [15:0] ch0_ofs_lo;
   logic [15:0] ch0_gain_hi;
   logic [15:0] ch0_gain_lo;
   logic [15:0] chan1_config;
   logic [15:0] ch1_ofs_hi;
   logic [15:0] glob;
   logic [9:0] ch0_phase_reg;
   logic ch0_dcoff_reg;
   ccc_sel_t ch0_sel_reg;
   logic [23:0] ch0_ofs_reg;
   logic [23:0] ch0_gain_reg;
   logic [9:0] ch1_phase_reg;
   logic ch1_dcoff_reg;
   ccc_sel_t ch1_sel_reg;
   logic [15:0] ch1_ofs_reg;
   logic [3:0] glob_reg;

   // Decode happens in the setup cycle; the answer comes one cycle later,
   // so every access has exactly one wait-free access phase.
   always_comb begin
      setup = psel & ~penable;
      word_idx = paddr[9:2];
      aligned = (paddr[1:0] == 2'b00) & (paddr[11:10] == 2'b00);
      sel_vec = '0;
      if (aligned) begin
         unique case (word_idx)
            CCC_IDX_GLOBAL_DC: sel_vec[0] = 1'b1;
            CCC_IDX_CHAN0_CONFIG: sel_vec[1] = 1'b1;
            CCC_IDX_CH0_OFS_HI: sel_vec[2] = 1'b1;
            CCC_IDX_CH0_OFS_LO: sel_vec[3] = 1'b1;
            CCC_IDX_CH0_GAIN_HI: sel_vec[4] = 1'b1;
            CCC_IDX_CH0_GAIN_LO: sel_vec[5] = 1'b1;
            CCC_IDX_CHAN1_CONFIG: sel_vec[6] = 1'b1;
            CCC_IDX_CH1_OFS_HI: sel_vec[7] = 1'b1;
            default: sel_vec = '0;
         endcase
      end
      hit = |sel_vec;
   end

   // Writes land at the completing edge; a cleared byte strobe keeps that byte.
   always_comb begin
      wr_vec = (psel & penable & pwrite) ? sel_vec : '0;
      rd_mux = '0;
      for (int i = 0; i < NREG; i++) begin
         if (sel_vec[i]) begin
            rd_mux = rd_vals[i];
         end
      end
      wr_word[7:0] = pstrb[0] ? pwdata[7:0] : rd_mux[7:0];
      wr_word[15:8] = pstrb[1] ? pwdata[15:8] : rd_mux[15:8];
   end

   // Register storage; reset values and writable masks set each layout.
   // shared filter setting
   ccc_reg16 #(.RESET_VALUE({12'h000, CCC_RST_GLOBAL_DC}), .WRITE_MASK(CCC_MASK_GLOBAL_DC))
      u_glob (.pclk(pclk), .presetn(presetn), .wr_en(wr_vec[0]), .wr_data(wr_word),
              .value(glob));
   ccc_reg16 #(.RESET_VALUE(CCC_RST_CFG), .WRITE_MASK(CCC_MASK_CFG))
      u_chan0_config (.pclk(pclk), .presetn(presetn), .wr_en(wr_vec[1]), .wr_data(wr_word),
                 .value(chan0_config));
   ccc_reg16 #(.RESET_VALUE(CCC_RST_OFS), .WRITE_MASK(CCC_MASK_FULL))
      u_ch0_ofs_hi (.pclk(pclk), .presetn(presetn), .wr_en(wr_vec[2]), .wr_data(wr_word),
                    .value(ch0_ofs_hi));
   ccc_reg16 #(.RESET_VALUE(CCC_RST_OFS), .WRITE_MASK(CCC_MASK_LOWBYTE_RSVD))
      u_ch0_ofs_lo (.pclk(pclk), .presetn(presetn), .wr_en(wr_vec[3]), .wr_data(wr_word),
                    .value(ch0_ofs_lo));
   ccc_reg16 #(.RESET_VALUE(CCC_RST_GAIN_HI), .WRITE_MASK(CCC_MASK_FULL))
      u_ch0_gain_hi (.pclk(pclk), .presetn(presetn), .wr_en(wr_vec[4]), .wr_data(wr_word),
                     .value(ch0_gain_hi));
   ccc_reg16 #(.RESET_VALUE(CCC_RST_GAIN_LO), .WRITE_MASK(CCC_MASK_LOWBYTE_RSVD))
      u_ch0_gain_lo (.pclk(pclk), .presetn(presetn), .wr_en(wr_vec[5]), .wr_data(wr_word),
                     .value(ch0_gain_lo));
   ccc_reg16 #(.RESET_VALUE(CCC_RST_CFG), .WRITE_MASK(CCC_MASK_CFG))
      u_chan1_config (.pclk(pclk), .presetn(presetn), .wr_en(wr_vec[6]), .wr_data(wr_word),
                 .value(chan1_config));
   ccc_reg16 #(.RESET_VALUE(CCC_RST_OFS), .WRITE_MASK(CCC_MASK_FULL))
      u_ch1_ofs_hi (.pclk(pclk), .presetn(presetn), .wr_en(wr_vec[7]), .wr_data(wr_word),
                    .value(ch1_ofs_hi));

   // Read values in decode order.
   always_comb begin
      rd_vals[0] = glob;
      rd_vals[1] = chan0_config;
      rd_vals[2] = ch0_ofs_hi;
      rd_vals[3] = ch0_ofs_lo;
      rd_vals[4] = ch0_gain_hi;
      rd_vals[5] = ch0_gain_lo;
      rd_vals[6] = chan1_config;
      rd_vals[7] = ch1_ofs_hi;
   end

   // Bus answer: pready rises in the access phase after a setup cycle.
   // reserved bits read zero
   always_comb begin
      pready_next = 1'b0;
      pslverr_next = 1'b0;
      prdata_next = '0;
      if (setup) begin
         pready_next = 1'b1;
         pslverr_next = ~hit;
         if (!pwrite && hit) begin
            prdata_next = {16'h0000, rd_mux};
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_reg <= 1'b0;
         pslverr_reg <= 1'b0;
         prdata_reg <= 32'h0000_0000;
      end else begin
         pready_reg <= pready_next;
         pslverr_reg <= pslverr_next;
         prdata_reg <= prdata_next;
      end
   end

   // Field outputs are re-registered so the converter sees flop outputs.
   // per-channel filter disable
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ch0_phase_reg <= 10'h000;
         ch0_dcoff_reg <= 1'b0;
         ch0_sel_reg <= CCC_SEL_PINS;
         ch0_ofs_reg <= 24'h000000;
         ch0_gain_reg <= {CCC_RST_GAIN_HI, 8'h00};
         ch1_phase_reg <= 10'h000;
         ch1_dcoff_reg <= 1'b0;
         ch1_sel_reg <= CCC_SEL_PINS;
         ch1_ofs_reg <= 16'h0000;
         glob_reg <= CCC_RST_GLOBAL_DC;
      end else begin
         ch0_phase_reg <= chan0_config[CCC_PHASE_MSB:CCC_PHASE_LSB];
         ch0_dcoff_reg <= chan0_config[CCC_DCOFF_BIT];
         ch0_sel_reg <= ccc_sel_t'(chan0_config[CCC_SEL_MSB:0]);
         ch0_ofs_reg <= {ch0_ofs_hi, ch0_ofs_lo[15:8]};
         ch0_gain_reg <= {ch0_gain_hi, ch0_gain_lo[15:8]};
         ch1_phase_reg <= chan1_config[CCC_PHASE_MSB:CCC_PHASE_LSB];
         ch1_dcoff_reg <= chan1_config[CCC_DCOFF_BIT];
         ch1_sel_reg <= ccc_sel_t'(chan1_config[CCC_SEL_MSB:0]);
         ch1_ofs_reg <= ch1_ofs_hi;
         glob_reg <= glob[3:0];
      end
   end

   assign prdata = prdata_reg;
   assign pready = pready_reg;
   assign pslverr = pslverr_reg;
   assign chan0_phase_delay = ch0_phase_reg;
   assign chan0_dc_filter_off = ch0_dcoff_reg;
   assign chan0_input_select = ch0_sel_reg;
   assign chan0_offset = ch0_ofs_reg;
   assign chan0_gain = ch0_gain_reg;
   assign chan1_phase_delay = ch1_phase_reg;
   assign chan1_dc_filter_off = ch1_dcoff_reg;
   assign chan1_input_select = ch1_sel_reg;
   assign chan1_offset_upper = ch1_ofs_reg;
   assign global_dc_filter_setting = glob_reg;
endmodule

/* hdl/ccc_pkg.sv */
// Package for the channel configuration and calibration register bank.
// Assumes a 32-bit APB slave with word-aligned registers at four times their index.
package ccc_pkg;
   // Register indices; the byte address is four times the index.
   localparam logic [7:0] CCC_IDX_GLOBAL_DC = 8'h08;
   localparam logic [7:0] CCC_IDX_CHAN0_CONFIG = 8'h09;
   localparam logic [7:0] CCC_IDX_CH0_OFS_HI = 8'h0A;
   localparam logic [7:0] CCC_IDX_CH0_OFS_LO = 8'h0B;
   localparam logic [7:0] CCC_IDX_CH0_GAIN_HI = 8'h0C;
   localparam logic [7:0] CCC_IDX_CH0_GAIN_LO = 8'h0D;
   localparam logic [7:0] CCC_IDX_CHAN1_CONFIG = 8'h0E;
   localparam logic [7:0] CCC_IDX_CH1_OFS_HI = 8'h0F;
   // Reset values.
   localparam logic [15:0] CCC_RST_CFG = 16'h0000;
   localparam logic [15:0] CCC_RST_OFS = 16'h0000;
   localparam logic [15:0] CCC_RST_GAIN_HI = 16'h8000;
   localparam logic [15:0] CCC_RST_GAIN_LO = 16'h0000;
   localparam logic [3:0] CCC_RST_GLOBAL_DC = 4'h0;
   // Writable bit masks of each register layout.
   localparam logic [15:0] CCC_MASK_CFG = 16'hFFC7;
   localparam logic [15:0] CCC_MASK_FULL = 16'hFFFF;
   localparam logic [15:0] CCC_MASK_LOWBYTE_RSVD = 16'hFF00;
   localparam logic [15:0] CCC_MASK_GLOBAL_DC = 16'h000F;
   // Field positions in a channel configuration word.
   localparam int CCC_PHASE_MSB = 15;
   localparam int CCC_PHASE_LSB = 6;
   localparam int CCC_DCOFF_BIT = 2;
   localparam int CCC_SEL_MSB = 1;
   // Input selection codes.
   typedef enum logic [1:0] {
      CCC_SEL_PINS = 2'b00,
      CCC_SEL_SHORT = 2'b01,
      CCC_SEL_POS_TEST = 2'b10,
      CCC_SEL_NEG_TEST = 2'b11
   } ccc_sel_t;
endpackage

/* hdl/ccc_reg16.sv */
// One 16-bit software register with a writable-bit mask.
// Assumes the caller gives a one-cycle write strobe in the pclk domain.
`timescale 1ns/1ps
module ccc_reg16 #(
   parameter logic [15:0] RESET_VALUE = 16'h0000,
   parameter logic [15:0] WRITE_MASK = 16'hFFFF
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic wr_en,
   input wire logic [15:0] wr_data,
   output logic [15:0] value
);
   logic [15:0] value_reg;
   logic [15:0] value_next;

   // Masked bits never take write data, so reserved bits stay at zero.
   always_comb begin
      value_next = value_reg;
      if (wr_en) begin
         value_next = (wr_data & WRITE_MASK) | (value_reg & ~WRITE_MASK);
      end
   end

   // Register stage.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         value_reg <= RESET_VALUE & WRITE_MASK;
      end else begin
         value_reg <= value_next;
      end
   end

   assign value = value_reg;
endmodule

/* testbench/ccc_regs_asserts.sv */
// Checker for the register bank, bound to every instance of it.
// Assumes the bank answers every setup cycle in the very next cycle.
`timescale 1ns/1ps
module ccc_regs_asserts
   import ccc_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [9:0] chan0_phase_delay,
   input wire logic chan0_dc_filter_off,
   input wire ccc_pkg::ccc_sel_t chan0_input_select,
   input wire logic [23:0] chan0_offset,
   input wire logic [23:0] chan0_gain
);
   import ccc_pkg::*;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // A setup cycle and a completed full-width write to one byte address.
   sequence s_setup;
      psel && !penable;
   endsequence
   sequence s_wr(a);
      psel && penable && pready && pwrite && paddr == a && pstrb[1:0] == 2'b11;
   endsequence
   // Fields are checked two edges on, which holds whether they lag by one cycle or not.
   chk_ready_after_setup: assert property (s_setup |=> pready)
      else $error("no answer after setup");
   chk_ready_single: assert property (pready |=> !pready)
      else $error("pready stood too long");
   chk_rdata_idle: assert property (!pready |-> prdata == 32'h0)
      else $error("read data outside answer");
   chk_unmapped_err: assert property (psel && !penable && paddr == 12'h040 |=> pslverr)
      else $error("unmapped access not refused");
   chk_reset_values: assert property (
      $rose(presetn) |-> chan0_gain == 24'h800000 && chan0_offset == 24'h000000)
      else $error("reset values wrong");
   chk_gain_hi_write: assert property (
      s_wr(12'h030) |-> ##2 chan0_gain[23:8] == $past(pwdata[15:0], 2))
      else $error("gain upper not applied");
   chk_ofs_lo_write: assert property (
      s_wr(12'h02C) |-> ##2 chan0_offset[7:0] == $past(pwdata[15:8], 2))
      else $error("offset lower not applied");
   chk_cfg_fields: assert property (
      s_wr(12'h024) |-> ##2 chan0_phase_delay == $past(pwdata[15:6], 2))
      else $error("phase delay not applied");
   chk_cfg_select: assert property (
      s_wr(12'h024) |-> ##2 chan0_input_select == $past(pwdata[1:0], 2)
      && chan0_dc_filter_off == $past(pwdata[2], 2))
      else $error("select or filter bit not applied");
endmodule
bind ccc_regs ccc_regs_asserts u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
   .prdata(prdata), .pready(pready), .pslverr(pslverr), .chan0_phase_delay(chan0_phase_delay),
   .chan0_dc_filter_off(chan0_dc_filter_off), .chan0_input_select(chan0_input_select),
   .chan0_offset(chan0_offset), .chan0_gain(chan0_gain));

/* testbench/tb_ccc_regs.sv */
// Self-checking bench for the register bank, driven as an APB master.
// Assumes the bank answers each setup cycle with one access cycle.
`timescale 1ns/1ps
module tb_ccc_regs;
   import ccc_pkg::*;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, dc0, dc1, er;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [3:0] pstrb, gdc;
   logic [9:0] ph0, ph1;
   ccc_sel_t sel0, sel1;
   logic [23:0] ofs0, gain0;
   logic [15:0] ofs1;
   logic [15:0] m [8:15];
   int bad_count, n_tests;
   ccc_regs u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .chan0_phase_delay(ph0), .chan0_dc_filter_off(dc0),
      .chan0_input_select(sel0), .chan0_offset(ofs0), .chan0_gain(gain0),
      .chan1_phase_delay(ph1), .chan1_dc_filter_off(dc1), .chan1_input_select(sel1),
      .chan1_offset_upper(ofs1), .global_dc_filter_setting(gdc));
   initial begin
      pclk = 1'b0;
      forever #2 pclk = ~pclk;
   end
   function automatic logic [15:0] wmask(int i);
      case (i)
         8: return 16'h000F;
         9, 14: return 16'hFFC7;
         11, 13: return 16'hFF00;
         default: return 16'hFFFF;
      endcase
   endfunction
   task automatic cmp(string nm, logic [31:0] e, logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         bad_count++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   // One transfer; the request is held until pready is seen at an edge, for at most 8 edges.
   task automatic apb(logic w, logic [11:0] a, logic [31:0] d, logic [3:0] s);
      int k;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      pstrb <= s;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 8);
      if (k >= 8) bad_count++;
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // Writes one index and keeps the model in step with the strobes.
   task automatic wr(int i, logic [31:0] d, logic [3:0] s);
      logic [15:0] sm;
      apb(1'b1, 12'(i * 4), d, s);
      cmp("write error", 32'(i < 8 || i > 15), 32'(er));
      sm = {{8{s[1]}}, {8{s[0]}}} & wmask(i);
      if (i >= 8 && i <= 15) m[i] = (m[i] & ~sm) | (d[15:0] & sm);
   endtask
   task automatic mreset();
      for (int i = 8; i <= 15; i++) m[i] = (i == 12) ? 16'h8000 : 16'h0000;
   endtask
   // Reads every index, one past each end, then every field output.
   task automatic chk_all();
      for (int i = 7; i <= 16; i++) begin
         apb(1'b0, 12'(i * 4), 32'h0, 4'h0);
         cmp("read data", (i < 8 || i > 15) ? 32'h0 : 32'(m[i]), rd);
         cmp("read error", 32'(i < 8 || i > 15), 32'(er));
      end
      cmp("ch0 phase", 32'(m[9][15:6]), 32'(ph0));
      cmp("ch0 filter off", 32'(m[9][2]), 32'(dc0));
      cmp("ch0 select", 32'(m[9][1:0]), 32'(sel0));
      cmp("ch0 offset", 32'({m[10], m[11][15:8]}), 32'(ofs0));
      cmp("ch0 gain", 32'({m[12], m[13][15:8]}), 32'(gain0));
      cmp("ch1 phase", 32'(m[14][15:6]), 32'(ph1));
      cmp("ch1 filter off", 32'(m[14][2]), 32'(dc1));
      cmp("ch1 select", 32'(m[14][1:0]), 32'(sel1));
      cmp("ch1 offset", 32'(m[15]), 32'(ofs1));
      cmp("global filter", 32'(m[8][3:0]), 32'(gdc));
   endtask
   initial begin
      repeat (20000) @(posedge pclk);
      bad_count++;
      tally_and_finish();
   end
   initial begin
      {psel, penable, pwrite, paddr, pwdata, pstrb, presetn} = '0;
      bad_count = 0;
      n_tests = 0;
      rd = $urandom(32'h2F96);
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      mreset();
      chk_all();
      for (int c = 0; c < 4; c++) begin
         wr(9, {16'h0, 10'h3FF, 4'hF, 2'(c)}, 4'hF);
         wr(14, {16'h0, 10'(c * 99), 4'h8, 2'(3 - c)}, 4'hF);
         chk_all();
      end
      wr(12, 32'hFFFF, 4'hF);
      wr(11, 32'hFFFF, 4'hF);
      wr(13, 32'hFFFF, 4'h3);
      chk_all();
      // Unaligned and out-of-range byte addresses must change nothing.
      apb(1'b1, 12'h031, 32'h1234, 4'hF);
      cmp("unaligned error", 32'h1, 32'(er));
      apb(1'b1, 12'h430, 32'h1234, 4'hF);
      cmp("high address error", 32'h1, 32'(er));
      repeat (60) begin
         wr($urandom_range(7, 16), $urandom,
            $urandom_range(0, 3) == 0 ? 4'($urandom) : 4'hF);
         chk_all();
      end
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      mreset();
      chk_all();
      tally_and_finish();
   end
endmodule
